//--- src/cms_pkg.sv
// shared constants and state type for the charger mode sequencer
package cms_pkg;
  // ==========================================================
  // mode states
  typedef enum logic [2:0] {
    CMS_SLEEP,
    CMS_POR,
    CMS_STANDBY,
    CMS_BEGIN,
    CMS_CHARGING,
    CMS_SUSPEND
  } cms_state_t;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 40000000;
  localparam int POR_DELAY_US = 1000; // power-on-reset delay, plain default
  localparam int POR_CYCLES = (POR_DELAY_US * (CLK_HZ / 1000000));
  localparam int TMR_W = 32;
  // precharge divisor: one tenth of programmed current
  localparam int PRE_DIV = 10;
  localparam int ITGT_W = 8;
  // status encoding, bit 1 = a, bit 0 = b, 1 = transistor on
  localparam logic [1:0] STAT_PRE = 2'h3;
  localparam logic [1:0] STAT_FAST = 2'h2;
  localparam logic [1:0] STAT_DONE = 2'h1;
  localparam logic [1:0] STAT_OFF = 2'h0;
endpackage

//--- src/cms_timer.sv
// safety timer counter with clear and hold
`timescale 1ns/100ps
`default_nettype none
module cms_timer #(
  parameter int W = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_clear,
  input wire logic i_run,
  output logic [W-1:0] o_count
);
  // ==========================================================
  // counter: clear wins, else count while run, else hold
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      o_count <= '0;
    else if (i_clear)
      o_count <= '0;
    else if (i_run && (o_count != {W{1'b1}}))
      o_count <= o_count + 1'b1;
  end
endmodule
`default_nettype wire

//--- src/cms_top.sv
// charger mode sequencer top level
`timescale 1ns/100ps
`default_nettype none
// Operation
// - start charge only with power qualified, enable low, battery below recharge level
// - safety timer runs from cycle start only when timer is enabled
// - below precharge level the current target is one tenth of programmed
// - below power-down level everything is off and all status outputs float
// - sleep keeps charger off, ignores inputs, floats status, power-good not detected
// - sleep is entered from any state once input power is lost
// - input detected in sleep moves to power-on-reset, starts delay, resets blocks
// - during power-on-reset delay status shows off and power-good not detected
// - after the delay comparators enable and all status outputs become active; code drives only power-good then, status pair stays off until charging
// - with enable variant, enable high after reset enters standby monitoring inputs
// - variants without enable go straight to begin-charge after reset
// - begin-charge resets all timers then enters charging
// - temperature out of range suspends, charger off, timers held
// - suspend resumes charging once temperature is back in range
// - timer pin open disables termination, battery detect, holds timer in reset
// - status pair encodes precharge, fast charge, done, else both off
// - overvoltage turns charger off to standby unlatched, recovers when cleared
// - standby resets timers, suspend keeps their counts
module cms_top #(
  parameter bit HAS_ENABLE = 1'b1,
  parameter int POR_CYCLES = cms_pkg::POR_CYCLES,
  parameter int TMR_W = cms_pkg::TMR_W,
  parameter int ITGT_W = cms_pkg::ITGT_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_input_detect,
  input wire logic i_overvoltage,
  input wire logic i_charge_en_n,
  input wire logic i_below_recharge,
  input wire logic i_below_precharge,
  input wire logic i_temp_ok,
  input wire logic i_timer_open,
  input wire logic i_terminated,
  input wire logic [ITGT_W-1:0] i_current_program,
  output logic o_pass_on,
  output logic [ITGT_W-1:0] o_current_target,
  output logic o_status_out_a_oe,
  output logic o_status_out_b_oe,
  output logic o_power_good_n_oe,
  output logic o_comparators_en,
  output logic o_blocks_rst,
  output logic o_term_detect_en,
  output logic o_timer_clear,
  output logic o_timer_run,
  output logic [TMR_W-1:0] o_timer_count
);
  // ==========================================================
  // input synchronisers
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
    end
    else
    begin
      s1_q <= {i_input_detect, i_overvoltage, i_charge_en_n, i_below_recharge,
               i_below_precharge, i_temp_ok, i_timer_open, i_terminated};
      s2_q <= s1_q;
    end
  end
  logic det;
  logic ovp;
  logic en_n;
  logic below_rch;
  logic below_pre;
  logic temp_ok;
  logic tmr_open;
  logic term;
  assign {det, ovp, en_n, below_rch, below_pre, temp_ok, tmr_open, term} = s2_q;
  logic [ITGT_W-1:0] prog_q;
  logic [ITGT_W-1:0] prog_s_q;
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      prog_s_q <= '0;
      prog_q <= '0;
    end
    else
    begin
      prog_s_q <= i_current_program;
      prog_q <= prog_s_q;
    end
  end

  // ==========================================================
  // mode state machine
  cms_pkg::cms_state_t state_q;
  logic [31:0] por_cnt_q;
  logic enable_ok;
  assign enable_ok = (!HAS_ENABLE || !en_n) && !ovp;
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      state_q <= cms_pkg::CMS_SLEEP;
    else if (!det)
      state_q <= cms_pkg::CMS_SLEEP;
    else
    begin
      unique case (state_q)
        cms_pkg::CMS_SLEEP: state_q <= cms_pkg::CMS_POR;
        cms_pkg::CMS_POR:
          if (por_cnt_q >= 32'(POR_CYCLES - 1))
            state_q <= HAS_ENABLE ? cms_pkg::CMS_STANDBY : cms_pkg::CMS_BEGIN;
        cms_pkg::CMS_STANDBY:
          if (enable_ok && below_rch)
            state_q <= cms_pkg::CMS_BEGIN;
        cms_pkg::CMS_BEGIN:
          if (!enable_ok)
            state_q <= cms_pkg::CMS_STANDBY;
          else if (below_rch)
            state_q <= cms_pkg::CMS_CHARGING;
        cms_pkg::CMS_CHARGING:
          if (!enable_ok)
            state_q <= cms_pkg::CMS_STANDBY;
          else if (!temp_ok)
            state_q <= cms_pkg::CMS_SUSPEND;
        cms_pkg::CMS_SUSPEND:
          if (!enable_ok)
            state_q <= cms_pkg::CMS_STANDBY;
          else if (temp_ok)
            state_q <= cms_pkg::CMS_CHARGING;
        default: state_q <= cms_pkg::CMS_SLEEP; // illegal codes fall back to sleep
      endcase
    end
  end

  // por delay counter, cleared outside por
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      por_cnt_q <= 32'h0;
    else if (state_q != cms_pkg::CMS_POR || !det)
      por_cnt_q <= 32'h0;
    else if (por_cnt_q != 32'hffffffff)
      por_cnt_q <= por_cnt_q + 32'h1;
  end

  // ==========================================================
  // safety timer
  logic tmr_clear;
  logic tmr_run;
  assign tmr_clear = tmr_open || (state_q == cms_pkg::CMS_STANDBY) ||
                     (state_q == cms_pkg::CMS_BEGIN) || (state_q == cms_pkg::CMS_SLEEP) ||
                     (state_q == cms_pkg::CMS_POR);
  assign tmr_run = (state_q == cms_pkg::CMS_CHARGING) && !tmr_open && !term;
  logic [TMR_W-1:0] tmr_count;
  cms_timer #(.W(TMR_W)) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_clear(tmr_clear),
    .i_run(tmr_run),
    .o_count(tmr_count)
  );

  // ==========================================================
  // output registers
  logic active;
  logic charging;
  assign active = (state_q != cms_pkg::CMS_SLEEP) && (state_q != cms_pkg::CMS_POR);
  assign charging = (state_q == cms_pkg::CMS_CHARGING) && temp_ok && enable_ok && det;
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_pass_on <= 1'b0;
      o_current_target <= '0;
      o_status_out_a_oe <= 1'b0;
      o_status_out_b_oe <= 1'b0;
      o_power_good_n_oe <= 1'b0;
      o_comparators_en <= 1'b0;
      o_blocks_rst <= 1'b1;
      o_term_detect_en <= 1'b0;
      o_timer_clear <= 1'b1;
      o_timer_run <= 1'b0;
      o_timer_count <= '0;
    end
    else
    begin
      o_pass_on <= charging && !(term && !tmr_open);
      o_current_target <= below_pre ? ITGT_W'(prog_q / cms_pkg::PRE_DIV) : prog_q;
      // status: pre / fast / done / off
      if (!charging)
        {o_status_out_a_oe, o_status_out_b_oe} <= cms_pkg::STAT_OFF;
      else if (term && !tmr_open)
        {o_status_out_a_oe, o_status_out_b_oe} <= cms_pkg::STAT_DONE;
      else if (below_pre)
        {o_status_out_a_oe, o_status_out_b_oe} <= cms_pkg::STAT_PRE;
      else
        {o_status_out_a_oe, o_status_out_b_oe} <= cms_pkg::STAT_FAST;
      o_power_good_n_oe <= active && det && !ovp;
      o_comparators_en <= active;
      o_blocks_rst <= !active;
      o_term_detect_en <= active && !tmr_open;
      o_timer_clear <= tmr_clear;
      o_timer_run <= tmr_run;
      o_timer_count <= tmr_count;
    end
  end

  // ==========================================================
  // assertions
  no_pass_sleep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == cms_pkg::CMS_SLEEP) |=> !o_pass_on) else $error("pass on in sleep");
  loss_sleep_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !det |=> (state_q == cms_pkg::CMS_SLEEP)) else $error("no sleep on power loss");
  sleep_por_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == cms_pkg::CMS_SLEEP) && det |=> (state_q == cms_pkg::CMS_POR))
    else $error("sleep did not enter por");
  por_quiet_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == cms_pkg::CMS_POR) |=> !o_power_good_n_oe && !o_status_out_a_oe)
    else $error("outputs active in por");
  begin_charge_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == cms_pkg::CMS_BEGIN) && det && enable_ok && below_rch
    |=> (state_q == cms_pkg::CMS_CHARGING) && (tmr_count == '0))
    else $error("begin charge wrong");
  suspend_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == cms_pkg::CMS_SUSPEND) && $past(state_q == cms_pkg::CMS_SUSPEND) &&
    !$past(tmr_open) |-> $stable(tmr_count)) else $error("timer moved in suspend");
  standby_clear_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == cms_pkg::CMS_STANDBY) |=> (tmr_count == '0)) else $error("standby kept timer");
  open_timer_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    tmr_open |=> (tmr_count == '0) && !o_term_detect_en) else $error("open pin timer ran");
  ovp_standby_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    det && ovp && (state_q == cms_pkg::CMS_CHARGING) |=> (state_q == cms_pkg::CMS_STANDBY))
    else $error("overvoltage not to standby");
  pre_target_a: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    below_pre |=> (o_current_target == ITGT_W'($past(prog_q) / cms_pkg::PRE_DIV)))
    else $error("precharge target wrong");
  cv_charge_c: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    state_q == cms_pkg::CMS_CHARGING);
  cv_suspend_c: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == cms_pkg::CMS_SUSPEND) ##1 (state_q == cms_pkg::CMS_CHARGING));
  cv_ovp_c: cover property (@(posedge i_clk_sys) disable iff (i_rst)
    (state_q == cms_pkg::CMS_CHARGING) && ovp);
endmodule
`default_nettype wire

//--- verification/cms_host_model.sv
// host controller model that drives the active-low charge enable
`timescale 1ns/100ps
`default_nettype none
module cms_host_model (
  input wire logic i_clk_sys,
  input wire logic i_enable_req,
  output logic o_charge_en_n
);
  // ==========================================================
  // enable pin, changed a short delay after the clock edge
  initial o_charge_en_n = 1'h1;
  always @(posedge i_clk_sys)
  begin
    o_charge_en_n <= #2 ~i_enable_req;
  end
endmodule
`default_nettype wire

//--- verification/tb_charger_mode_sequencer.sv
// self-checking testbench for the charger mode sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_charger_mode_sequencer;
  logic clk, rst, det, ovp, en_req, en_n, brch, bpre, tok, topen, term;
  logic pass, sa, sb, pg, cmp, brst, tden, tclr, trun;
  logic pass2;
  logic [7:0] prog, tgt;
  logic [31:0] cnt, held;
  int mismatches = 0;
  int checks_done = 0;
  // ==========================================================
  // design and host model
  cms_top #(.POR_CYCLES(8)) dut_u (
    .i_clk_sys(clk), .i_rst(rst), .i_input_detect(det), .i_overvoltage(ovp),
    .i_charge_en_n(en_n), .i_below_recharge(brch), .i_below_precharge(bpre),
    .i_temp_ok(tok), .i_timer_open(topen), .i_terminated(term),
    .i_current_program(prog), .o_pass_on(pass), .o_current_target(tgt),
    .o_status_out_a_oe(sa), .o_status_out_b_oe(sb), .o_power_good_n_oe(pg),
    .o_comparators_en(cmp), .o_blocks_rst(brst), .o_term_detect_en(tden),
    .o_timer_clear(tclr), .o_timer_run(trun), .o_timer_count(cnt)
  );
  // variant without enable input, sharing the same stimulus
  cms_top #(.HAS_ENABLE(1'b0), .POR_CYCLES(8)) dut_ne_u (
    .i_clk_sys(clk), .i_rst(rst), .i_input_detect(det), .i_overvoltage(ovp),
    .i_charge_en_n(en_n), .i_below_recharge(brch), .i_below_precharge(bpre),
    .i_temp_ok(tok), .i_timer_open(topen), .i_terminated(term),
    .i_current_program(prog), .o_pass_on(pass2), .o_current_target(),
    .o_status_out_a_oe(), .o_status_out_b_oe(), .o_power_good_n_oe(),
    .o_comparators_en(), .o_blocks_rst(), .o_term_detect_en(),
    .o_timer_clear(), .o_timer_run(), .o_timer_count()
  );
  cms_host_model host_u (.i_clk_sys(clk), .i_enable_req(en_req), .o_charge_en_n(en_n));
  // clock of 25 ns
  initial
  begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // helpers
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_sleep_por();
    chk("blocks_rst", 32'h1, {31'h0, brst});
    chk("timer_clear", 32'h1, {31'h0, tclr});
    en_req = 1'h1;
    wait_cyc(6);
    chk("sleep pass", 32'h0, {31'h0, pass});
    chk("sleep outs", 32'h0, {29'h0, sa, sb, pg});
    en_req = 1'h0;
    det = 1'h1;
    wait_cyc(5);
    chk("por outs", 32'h0, {29'h0, sa, sb, pg});
    chk("por cmp", 32'h0, {31'h0, cmp});
    chk("por blocks_rst", 32'h1, {31'h0, brst});
    wait_cyc(10);
    chk("pg active", 32'h1, {31'h0, pg});
    chk("cmp on", 32'h1, {31'h0, cmp});
    chk("standby pass", 32'h0, {31'h0, pass});
    chk("standby clear", 32'h1, {31'h0, tclr});
    chk("no enable variant pass", 32'h1, {31'h0, pass2});
    $display("test sleep_por done");
  endtask
  task automatic t_charge();
    en_req = 1'h1;
    brch = 1'h0;
    wait_cyc(8);
    chk("no recharge need pass", 32'h0, {31'h0, pass});
    brch = 1'h1;
    wait_cyc(8);
    chk("pre pass", 32'h1, {31'h0, pass});
    chk("pre target", 32'ha, {24'h0, tgt});
    chk("pre status", {30'h0, cms_pkg::STAT_PRE}, {30'h0, sa, sb});
    chk("timer run", 32'h1, {31'h0, trun});
    chk("term en", 32'h1, {31'h0, tden});
    bpre = 1'h0;
    wait_cyc(6);
    chk("fast target", 32'h64, {24'h0, tgt});
    chk("fast status", {30'h0, cms_pkg::STAT_FAST}, {30'h0, sa, sb});
    $display("test charge done");
  endtask
  task automatic t_suspend_ovp();
    tok = 1'h0;
    wait_cyc(6);
    held = cnt;
    chk("susp pass", 32'h0, {31'h0, pass});
    chk("susp nonzero", 32'h1, {31'h0, held != 32'h0});
    wait_cyc(5);
    chk("susp held", held, cnt);
    tok = 1'h1;
    wait_cyc(6);
    chk("resume pass", 32'h1, {31'h0, pass});
    chk("resume count", 32'h1, {31'h0, cnt > held});
    ovp = 1'h1;
    wait_cyc(6);
    chk("ovp pass", 32'h0, {31'h0, pass});
    chk("ovp clear", 32'h1, {31'h0, tclr});
    ovp = 1'h0;
    wait_cyc(10);
    chk("ovp recover", 32'h1, {31'h0, pass});
    $display("test suspend_ovp done");
  endtask
  task automatic t_done_ldo();
    term = 1'h1;
    wait_cyc(6);
    chk("done status", {30'h0, cms_pkg::STAT_DONE}, {30'h0, sa, sb});
    chk("done pass", 32'h0, {31'h0, pass});
    topen = 1'h1;
    wait_cyc(6);
    chk("ldo term", 32'h0, {31'h0, tden});
    chk("ldo clear", 32'h1, {31'h0, tclr});
    chk("ldo count", 32'h0, cnt);
    chk("ldo status", {30'h0, cms_pkg::STAT_FAST}, {30'h0, sa, sb});
    det = 1'h0;
    wait_cyc(6);
    chk("loss pass", 32'h0, {31'h0, pass});
    chk("loss outs", 32'h0, {29'h0, sa, sb, pg});
    det = 1'h1;
    wait_cyc(4);
    rst = 1'h1;
    wait_cyc(1);
    chk("mid reset", 32'h0, {28'h0, pass, sa, sb, pg});
    rst = 1'h0;
    $display("test done_ldo done");
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'h1; det = 1'h0; ovp = 1'h0; en_req = 1'h0; brch = 1'h1; bpre = 1'h1;
    tok = 1'h1; topen = 1'h0; term = 1'h0; prog = 8'h64;
    wait_cyc(2);
    rst = 1'h0;
    t_sleep_por();
    t_charge();
    t_suspend_ovp();
    t_done_ldo();
    end_of_test();
  end
  // watchdog
  initial
  begin
    #(25 * 3000);
    mismatches++;
    end_of_test();
  end
endmodule
`default_nettype wire
